// ### hw/watchdog_pkg.sv
// Shared constants and types of the watchdog device and its system end
package watchdog_pkg;
   // Register map seen by the system end
   localparam logic [7:0] WATCHDOG_CONTROL_OFS = 8'haa;
   localparam int         RUN_BIT              = 7;
   localparam int         CLEAR_BIT            = 6;
   localparam int         TIMEOUT_BIT          = 5;
   localparam int         LP_RUN_BIT           = 4;
   localparam int         CAUSE_BIT            = 3;
   localparam int         PSEL_HI              = 2;
   localparam logic [2:0] PSEL_POR             = 3'h7;
   localparam logic [7:0] CONFIG_RESET         = 8'hff;
   localparam int         MODE_HI              = 7;
   localparam int         MODE_LO              = 4;
   localparam logic [3:0] MODE_GP              = 4'hf;
   localparam logic [3:0] MODE_HALT_LP         = 4'h5;
   localparam logic [7:0] READ_ZERO            = 8'h00;
   // Timing
   localparam int CLK_PERIOD_NS      = 50;
   localparam int LOSC_PERIOD_NS     = 100000;
   localparam int LOSC_CYCLES        = LOSC_PERIOD_NS / CLK_PERIOD_NS;
   localparam int TIMEOUT_PERIODS    = 64;
   localparam int RESET_WINDOW_OSC   = 512;
   localparam logic [10:0] LOSC_LAST = 11'(LOSC_CYCLES - 1);
   localparam logic [5:0]  CNT_LAST  = 6'(TIMEOUT_PERIODS - 1);
   localparam logic [9:0]  WIN_LAST  = 10'(RESET_WINDOW_OSC - 1);
   // System end registers
   localparam logic [3:0] H_FWD  = 4'h0;
   localparam logic [3:0] H_CFG  = 4'h1;
   localparam logic [3:0] H_PWR  = 4'h2;
   localparam logic [3:0] H_STAT = 4'h3;
   localparam logic [3:0] H_RST  = 4'h4;
   localparam logic [3:0] H_RAW  = 4'h5;
   localparam int PWR_IDLE_BIT   = 0;
   localparam int PWR_PDOWN_BIT  = 1;
   localparam int STAT_IRQ_BIT   = 0;
   localparam int STAT_WDRST_BIT = 1;
   localparam int STAT_WAKE_BIT  = 2;

   typedef enum logic [1:0] {
      WIN_IDLE = 2'b01,
      WIN_WAIT = 2'b10
   } win_state_t;

   // Divider limit for the prescale field
   function automatic logic [7:0] presc_limit(input logic [2:0] sel);
      case (sel)
         3'h0:    presc_limit = 8'h00;
         3'h1:    presc_limit = 8'h03;
         3'h2:    presc_limit = 8'h07;
         3'h3:    presc_limit = 8'h0f;
         3'h4:    presc_limit = 8'h1f;
         3'h5:    presc_limit = 8'h3f;
         3'h6:    presc_limit = 8'h7f;
         default: presc_limit = 8'hff;
      endcase
   endfunction
endpackage

// ### hw/watchdog_if.sv
// Connection between the watchdog device and the system end
`timescale 1ns/1ps
`default_nettype none
interface watchdog_if;
   logic [7:0] addr;
   logic [7:0] wdata;
   logic       wr;
   logic       rd;
   logic       ta_ok;
   logic [7:0] rdata;
   logic [7:0] config_byte;
   logic       idle;
   logic       pdown;
   logic       sys_rst;
   logic       sys_rst_wdt;
   logic       wake;
   logic       irq;
   logic       rst_req;

   modport device (input addr, wdata, wr, rd, ta_ok, config_byte, idle,
                   pdown, sys_rst, sys_rst_wdt,
                   output rdata, wake, irq, rst_req);
   modport host (output addr, wdata, wr, rd, ta_ok, config_byte, idle,
                 pdown, sys_rst, sys_rst_wdt,
                 input rdata, wake, irq, rst_req);
endinterface
`default_nettype wire

// ### hw/watchdog_device.sv
// Watchdog device: counter, prescaler, control register, reset window
// Overview of operation
// - Mode all ones: general purpose timer only
// - Mode 0101: reset timer halting in low power
// - Other modes: reset timer running in low power
// - Counter clocked by selectable low-speed divider
// - Time-out wakes system, raises interrupt event
// - Reset timer issues reset if never cleared
// - Run bit starts/stops counter, general mode only
// - Writing clear bit one zeroes counter
// - Clear bit reads one while clear pending
// - Time-out flag set by overflow, software clears
// - Low power run bit, general mode only
// - Cause flag: set by watchdog reset, POR clears
// - Software should clear cause flag after reset
// - Prescale field selects divide 1 to 256
// - POR sets prescale to max, else kept
// - Time-out is 64 divided oscillator periods
// - Control writes only through timed access
// - Divided system clock breaks power-down reset
// - Reset after 512 oscillator clocks without clear
// - Low power entry, exit, reset clear counter
// - General mode keeps running after time-out
//
// The address-and-strobe port was decided locally.
`timescale 1ns/1ps
`default_nettype none
module watchdog_device
   import watchdog_pkg::*;
(
   input  wire logic   core_clk_i,
   input  wire logic   rst_n_i,
   watchdog_if.device  bus
);
   typedef struct packed {
      logic [10:0] osc_cnt;
      logic [7:0]  presc;
      logic [5:0]  cnt;
      logic        run;
      logic        clr_pend;
      logic        tflag;
      logic        lp_run;
      logic        cause;
      logic [2:0]  psel;
      win_state_t  win;
      logic [9:0]  win_cnt;
      logic        lp_q;
      logic [7:0]  rdata;
      logic        wake;
      logic        rst_req;
   } dev_state_t;

   dev_state_t s;
   dev_state_t next_s;

   logic [3:0] mode;
   logic       gp;
   logic       halt_lp;
   logic       lp;
   logic       tick;
   logic       running;
   logic       div_tick;
   logic       ovf;
   logic       wr_hit;
   logic [7:0] ctrl_val;

   assign mode    = bus.config_byte[MODE_HI:MODE_LO];
   assign gp      = (mode == MODE_GP);
   assign halt_lp = (mode == MODE_HALT_LP);
   assign lp      = bus.idle | bus.pdown;
   assign tick    = (s.osc_cnt == LOSC_LAST);
   // Run and low power run bits are ignored outside general mode
   assign running = gp ? (s.run && (!lp || s.lp_run))
                       : (!halt_lp || !lp);
   assign div_tick = tick && running
                     && (s.presc == presc_limit(s.psel));
   assign ovf     = div_tick && (s.cnt == CNT_LAST);
   // Timed access guard gates every control write
   assign wr_hit  = bus.wr && bus.ta_ok
                    && (bus.addr == WATCHDOG_CONTROL_OFS);
   assign ctrl_val = {s.run, s.clr_pend, s.tflag, s.lp_run, s.cause,
                      s.psel};

   always_comb begin
      next_s = s;
      next_s.wake    = 1'b0;
      next_s.rst_req = 1'b0;
      next_s.lp_q    = lp;
      next_s.osc_cnt = tick ? 11'h000 : s.osc_cnt + 11'h001;

      if (tick && running) begin
         next_s.presc = div_tick ? 8'h00 : s.presc + 8'h01;
      end
      if (div_tick) begin
         // Wraps and keeps counting after each time-out
         next_s.cnt = s.cnt + 6'h01;
      end
      if (ovf) begin
         next_s.wake = lp;
         if (!gp && (s.win == WIN_IDLE)) begin
            next_s.win     = WIN_WAIT;
            next_s.win_cnt = 10'h000;
         end
      end

      // Reset window counts oscillator clocks, not divided ones
      if ((s.win == WIN_WAIT) && tick) begin
         case (s.win)
            WIN_WAIT: begin
               next_s.win_cnt = s.win_cnt + 10'h001;
               if (s.win_cnt == WIN_LAST) begin
                  next_s.rst_req = 1'b1;
                  next_s.win     = WIN_IDLE;
               end
            end
            default: next_s.win = WIN_IDLE;
         endcase
      end
      // A mode change to general purpose drops a running window
      if (gp) begin
         next_s.win = WIN_IDLE;
      end

      // Clear lands on the oscillator edge, so it stays pending until then
      if (tick && s.clr_pend) begin
         next_s.cnt      = 6'h00;
         next_s.presc    = 8'h00;
         next_s.clr_pend = 1'b0;
         next_s.win      = WIN_IDLE;
         next_s.rst_req  = 1'b0;
      end

      if (lp != s.lp_q) begin
         next_s.cnt   = 6'h00;
         next_s.presc = 8'h00;
      end

      if (wr_hit) begin
         next_s.run    = bus.wdata[RUN_BIT];
         next_s.tflag  = bus.wdata[TIMEOUT_BIT];
         next_s.lp_run = bus.wdata[LP_RUN_BIT];
         next_s.cause  = bus.wdata[CAUSE_BIT];
         next_s.psel   = bus.wdata[PSEL_HI:0];
         if (bus.wdata[CLEAR_BIT]) begin
            next_s.clr_pend = 1'b1;
         end
      end
      // Hardware set wins over a software clear in the same cycle
      if (ovf) begin
         next_s.tflag = 1'b1;
      end

      if (bus.sys_rst) begin
         next_s.cnt      = 6'h00;
         next_s.presc    = 8'h00;
         next_s.run      = 1'b0;
         next_s.clr_pend = 1'b0;
         next_s.tflag    = 1'b0;
         next_s.lp_run   = 1'b0;
         next_s.win      = WIN_IDLE;
         next_s.win_cnt  = 10'h000;
         next_s.rst_req  = 1'b0;
         next_s.wake     = 1'b0;
         next_s.cause    = s.cause | bus.sys_rst_wdt;
         next_s.psel     = s.psel;
      end

      next_s.rdata = (bus.rd && (bus.addr == WATCHDOG_CONTROL_OFS))
                     ? ctrl_val : READ_ZERO;
   end

   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s         <= '0;
         s.psel    <= PSEL_POR;
         s.cause   <= 1'b0;
         s.win     <= WIN_IDLE;
      end else begin
         s <= next_s;
      end
   end

   assign bus.rdata   = s.rdata;
   assign bus.irq     = s.tflag;
   assign bus.wake    = s.wake;
   assign bus.rst_req = s.rst_req;
endmodule
`default_nettype wire

// ### hw/watchdog_host.sv
// System end: register port, timed access, power modes, system reset
`timescale 1ns/1ps
`default_nettype none
module watchdog_host
   import watchdog_pkg::*;
(
   input  wire logic       core_clk_i,
   input  wire logic       rst_n_i,
   input  wire logic [3:0] addr_i,
   input  wire logic [7:0] wdata_i,
   input  wire logic       wr_i,
   input  wire logic       rd_i,
   output logic      [7:0] rdata_o,
   output logic            cpu_reset_o,
   output logic            irq_o,
   watchdog_if.host        bus
);
   typedef struct packed {
      logic [7:0] cfg;
      logic       idle;
      logic       pdown;
      logic       wdrst_seen;
      logic       wake_seen;
      logic       sys_rst;
      logic       sys_rst_wdt;
      logic       rd_fwd;
      logic [7:0] rdata;
   } host_state_t;

   host_state_t s;
   host_state_t next_s;

   logic       fwd_wr;
   logic       raw_wr;
   logic [7:0] stat_val;

   assign fwd_wr   = wr_i && (addr_i == H_FWD);
   assign raw_wr   = wr_i && (addr_i == H_RAW);
   assign stat_val = {5'h00, s.wake_seen, s.wdrst_seen, bus.irq};

   always_comb begin
      next_s = s;
      next_s.sys_rst     = 1'b0;
      next_s.sys_rst_wdt = 1'b0;
      next_s.rd_fwd      = rd_i && (addr_i == H_FWD);
      if (wr_i) begin
         case (addr_i)
            H_CFG:   next_s.cfg = wdata_i;
            H_PWR: begin
               next_s.idle  = wdata_i[PWR_IDLE_BIT];
               next_s.pdown = wdata_i[PWR_PDOWN_BIT];
            end
            H_STAT: begin
               if (wdata_i[STAT_WDRST_BIT]) begin
                  next_s.wdrst_seen = 1'b0;
               end
               if (wdata_i[STAT_WAKE_BIT]) begin
                  next_s.wake_seen = 1'b0;
               end
            end
            H_RST:   next_s.sys_rst = wdata_i[0];
            default: next_s.cfg = s.cfg;
         endcase
      end
      // A wake ends either low power mode; set wins over clear
      if (bus.wake) begin
         next_s.idle      = 1'b0;
         next_s.pdown     = 1'b0;
         next_s.wake_seen = 1'b1;
      end
      if (bus.rst_req) begin
         next_s.sys_rst     = 1'b1;
         next_s.sys_rst_wdt = 1'b1;
         next_s.idle        = 1'b0;
         next_s.pdown       = 1'b0;
         next_s.wdrst_seen  = 1'b1;
      end
      case (addr_i)
         H_CFG:   next_s.rdata = s.cfg;
         H_PWR:   next_s.rdata = {6'h00, s.pdown, s.idle};
         H_STAT:  next_s.rdata = stat_val;
         default: next_s.rdata = READ_ZERO;
      endcase
      if (!rd_i) begin
         next_s.rdata = READ_ZERO;
      end
   end

   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s     <= '0;
         s.cfg <= CONFIG_RESET;
      end else begin
         s <= next_s;
      end
   end

   // Only the forward port carries the timed access unlock
   assign bus.addr        = WATCHDOG_CONTROL_OFS;
   assign bus.wdata       = wdata_i;
   assign bus.wr          = fwd_wr | raw_wr;
   assign bus.ta_ok       = fwd_wr;
   assign bus.rd          = rd_i && (addr_i == H_FWD);
   assign bus.config_byte = s.cfg;
   assign bus.idle        = s.idle;
   assign bus.pdown       = s.pdown;
   assign bus.sys_rst     = s.sys_rst;
   assign bus.sys_rst_wdt = s.sys_rst_wdt;
   assign rdata_o         = s.rd_fwd ? bus.rdata : s.rdata;
   assign cpu_reset_o     = s.sys_rst;
   assign irq_o           = bus.irq;
endmodule
`default_nettype wire

// ### tb/watchdog_reset_timer_sva.sv
// Assertions on the link between watchdog device and system end
`timescale 1ns/1ps
`default_nettype none
module watchdog_reset_timer_sva
   import watchdog_pkg::*;
(
   input wire logic       core_clk_i,
   input wire logic       rst_n_i,
   input wire logic [7:0] addr,
   input wire logic [7:0] wdata,
   input wire logic       wr,
   input wire logic       rd,
   input wire logic       ta_ok,
   input wire logic [7:0] rdata,
   input wire logic [7:0] config_byte,
   input wire logic       idle,
   input wire logic       pdown,
   input wire logic       sys_rst,
   input wire logic       sys_rst_wdt,
   input wire logic       wake,
   input wire logic       irq,
   input wire logic       rst_req
);
   logic ctl_wr;
   logic ctl_rd;
   assign ctl_wr = wr && ta_ok && addr == WATCHDOG_CONTROL_OFS;
   assign ctl_rd = rd && addr == WATCHDOG_CONTROL_OFS;
   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (!rst_n_i);

   chk_irq_mirror: assert property (
      ctl_rd |=> rdata[TIMEOUT_BIT] == $past(irq))
      else $error("irq differs from read flag");
   chk_flag_sticky: assert property (
      $fell(irq) |-> $past(ctl_wr && !wdata[TIMEOUT_BIT] || sys_rst))
      else $error("flag dropped without software clear");
   chk_flag_write: assert property (
      ctl_wr && wdata[TIMEOUT_BIT] && !sys_rst |=> irq)
      else $error("flag write not taken");
   chk_wake_pulse: assert property (
      wake |=> !wake)
      else $error("wake longer than one cycle");
   chk_wake_lowpwr: assert property (
      wake |-> irq && $past(idle || pdown))
      else $error("wake without time-out in low power");
   chk_reset_follow: assert property (
      rst_req |=> sys_rst && sys_rst_wdt)
      else $error("expired window gave no system reset");
   chk_gp_no_reset: assert property (
      rst_req |-> config_byte[MODE_HI:MODE_LO] != MODE_GP)
      else $error("reset request in general purpose mode");
   chk_cause_set: assert property (
      sys_rst && sys_rst_wdt ##2 ctl_rd |=> rdata[CAUSE_BIT])
      else $error("cause flag not set by watchdog reset");
   // Gap cycle keeps a second write from hiding the first
   chk_prescale_echo: assert property (
      ctl_wr ##1 !wr ##1 ctl_rd |=>
         rdata[PSEL_HI:0] == $past(wdata[PSEL_HI:0], 3))
      else $error("prescale field not stored");
   chk_warm_clear: assert property (
      sys_rst |=> !irq)
      else $error("warm reset left flag set");
endmodule
`default_nettype wire

// ### tb/tb_watchdog_reset_timer.sv
// Self-checking bench for the watchdog device and its system end
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin \
   n_errors++; $display("CHECK FAILED t=%0t got=%h exp=%h", $time, \
   (got), (exp)); end end
module tb_watchdog_reset_timer
   import watchdog_pkg::*;
;
   logic       core_clk_i;
   logic       rst_n_i;
   logic [3:0] addr_i;
   logic [7:0] wdata_i;
   logic       wr_i;
   logic       rd_i;
   logic [7:0] rdata_o;
   logic       cpu_reset_o;
   logic       irq_o;
   logic [7:0] v;
   int         n_errors;
   int         checks;
   int         n_rst;
   int         k;

   watchdog_if wif ();
   watchdog_device u_watchdog_device (.core_clk_i(core_clk_i),
      .rst_n_i(rst_n_i), .bus(wif));
   watchdog_host u_watchdog_host (.core_clk_i(core_clk_i),
      .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
      .rd_i(rd_i), .rdata_o(rdata_o), .cpu_reset_o(cpu_reset_o),
      .irq_o(irq_o), .bus(wif));
   watchdog_reset_timer_sva u_watchdog_reset_timer_sva (
      .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .addr(wif.addr),
      .wdata(wif.wdata), .wr(wif.wr), .rd(wif.rd), .ta_ok(wif.ta_ok),
      .rdata(wif.rdata), .config_byte(wif.config_byte), .idle(wif.idle),
      .pdown(wif.pdown), .sys_rst(wif.sys_rst),
      .sys_rst_wdt(wif.sys_rst_wdt), .wake(wif.wake), .irq(wif.irq),
      .rst_req(wif.rst_req));

   initial begin
      core_clk_i = 1'b0;
      // Undivided system clock keeps the watchdog reset usable
      forever #(CLK_PERIOD_NS / 2) core_clk_i = ~core_clk_i;
   end

   // Negedge sampling keeps the pulse count free of edge races
   always @(negedge core_clk_i) begin
      if (cpu_reset_o === 1'b1) n_rst++;
   end

   task automatic end_of_test;
      if (n_errors == 0 && checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // Idle cycle after each strobe so no signal is set twice in a step
   task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge core_clk_i);
      wr_i <= 1'b0;
      @(posedge core_clk_i);
   endtask

   task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge core_clk_i);
      rd_i <= 1'b0;
      #1 d = rdata_o;
      @(posedge core_clk_i);
   endtask

   task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
      rd_reg(a, v);
      `CHK(v, e)
   endtask

   initial begin
      n_errors = 0;
      checks = 0;
      n_rst = 0;
      rst_n_i = 1'b0;
      addr_i = 4'h0;
      wdata_i = 8'h00;
      wr_i = 1'b0;
      rd_i = 1'b0;
      repeat (8) @(posedge core_clk_i);
      rst_n_i <= 1'b1;
      @(posedge core_clk_i);
      rd_chk(H_FWD, {5'h00, PSEL_POR});
      rd_chk(H_CFG, CONFIG_RESET);
      rd_chk(H_STAT, 8'h00);
      rd_chk(4'h6, 8'h00);
      wr_reg(H_RAW, 8'hff);
      rd_chk(H_FWD, 8'h07);
      for (int i = 0; i < 8; i++) begin
         wr_reg(H_FWD, 8'(i));
         rd_chk(H_FWD, 8'(i));
      end
      wr_reg(H_FWD, 8'h0b);
      wr_reg(H_RST, 8'h01);
      repeat (2) @(posedge core_clk_i);
      `CHK(n_rst, 1)
      rd_chk(H_FWD, 8'h0b);
      wr_reg(H_FWD, 8'h4b);
      rd_chk(H_FWD, 8'h4b);
      k = 0;
      do begin
         rd_reg(H_FWD, v);
         k++;
      end while (v[CLEAR_BIT] !== 1'b0 && k < 1500);
      `CHK(v, 8'h0b)
      if (k >= 1500) end_of_test();
      // Entering idle restarts the count, so the interval is known to within one oscillator period
      wr_reg(H_FWD, 8'h90);
      wr_reg(H_PWR, 8'h01);
      k = 0;
      while (irq_o !== 1'b1 && k < 130000) begin
         @(negedge core_clk_i);
         k++;
      end
      `CHK(k >= 125990 && k <= 128010, 1'b1)
      if (k >= 130000) end_of_test();
      @(posedge core_clk_i);
      rd_chk(H_STAT, 8'h05);
      rd_chk(H_PWR, 8'h00);
      rd_chk(H_FWD, 8'hb0);
      wr_reg(H_FWD, 8'h00);
      rd_chk(H_FWD, 8'h00);
      rd_chk(H_STAT, 8'h04);
      end_of_test();
   end
endmodule
`default_nettype wire
